// [verilog/timer_pkg.sv]
package timer_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_RUN_CTRL   = 6'h0e;
    localparam logic [5:0] IDX_T0_CTRL    = 6'h0f;
    localparam logic [5:0] IDX_RELOAD_HI  = 6'h10;
    localparam logic [5:0] IDX_RELOAD_LO  = 6'h11;
    localparam logic [5:0] IDX_COUNT_HI   = 6'h12;
    localparam logic [5:0] IDX_COUNT_LO   = 6'h13;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
    localparam logic [5:0] IDX_IRQ_MASK   = 6'h21;
    localparam int unsigned IDX_LSB       = 2;
    localparam int unsigned IDX_MSB       = 7;

    // Run-control fields
    localparam int unsigned RUN_LSB       = 4;
    localparam int unsigned EN_LSB        = 0;
    localparam int unsigned TIMERS        = 4;

    // Timer zero control fields
    localparam int unsigned STOP_RX_BIT   = 7;
    localparam int unsigned START_MSB     = 5;
    localparam int unsigned START_LSB     = 4;
    localparam int unsigned AUTO_BIT      = 3;
    localparam int unsigned CLKSEL_MSB    = 1;
    localparam int unsigned CLKSEL_LSB    = 0;
    localparam logic [7:0]  CTRL_RW_MASK  = 8'hbb;

    // Interrupt status and mask fields
    localparam int unsigned UF_IRQ_BIT    = 0;

    // Reset values
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [7:0]  RELOAD_RESET  = 8'h00;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;

    // Count clock derivation from the bus clock
    localparam int unsigned SYS_PERIOD_PS = 4000;
    localparam int unsigned SYS_CLK_KHZ   = 1000000000 / SYS_PERIOD_PS;
    localparam int unsigned CNT_CLK_KHZ   = 13560;
    localparam int unsigned SLOW_CLK_HZ   = 211875;
    localparam int unsigned SLOW_DIV      = CNT_CLK_KHZ * 1000 / SLOW_CLK_HZ;
    // Sum reaches about 263,500 before the subtract, so 18 bits wrap
    localparam int unsigned ACC_W         = 19;
    localparam int unsigned SLOW_W        = $clog2(SLOW_DIV);

    // AXI responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {
        START_NONE   = 2'h0,
        START_TX_END = 2'h1,
        START_LFO    = 2'h2,
        START_LFO_UF = 2'h3
    } start_mode_type;

    typedef enum logic [1:0] {
        CLK_SYS     = 2'h0,
        CLK_SLOW    = 2'h1,
        CLK_T2_UF   = 2'h2,
        CLK_T1_UF   = 2'h3
    } clock_select_type;

    typedef enum logic [1:0] {
        T0_STOPPED = 2'h1,
        T0_RUNNING = 2'h2
    } t0_state_type;

endpackage

// [verilog/timer_run_control.sv]
`timescale 1ns/100ps
// Notes on behaviour
// - A write changes run bits 7..4 only where the same write sets enable bits 3..0.
// - Bits 7..4 show timers three..zero running; enabled write starts or stops.
// - Enable bits 3..0 are write-only and act only within their own write.
// - Stop-on-receive stops timer zero once first four received bits arrive.
// - In oscillator trimming modes the stop-on-receive bit is ignored.
// - Start mode 00 means no auto start; 01 starts at end of transmission.
// - Modes 10/11 trim oscillator on positive edges, without/with underflow.
// - With auto-restart set, reaching zero reloads and keeps counting down.
// - With auto-restart clear, reaching zero stops timer and clears running.
// - Every underflow of timer zero sets the timer interrupt flag.
// - Clock select 00 uses 13.56 MHz tick, 01 uses 211.875 kHz tick.
// - Clock select 10 counts timer two underflows, 11 timer one underflows.
// - Each start event loads the counter from the 16-bit reload value.
// - Reload writes leave a running count alone until the next start or auto-restart reload.
// - Low reload byte is readable and writable by software.
module timer_run_control
    import timer_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address and data
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // AXI4-Lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Radio and oscillator events, asynchronous pins
    input  wire logic        tx_end,
    input  wire logic        rx_nibble,
    input  wire logic        lfo_clock,
    // Neighbouring timers, same clock
    input  wire logic        timer_one_underflow,
    input  wire logic        timer_two_underflow,
    input  wire logic [3:1]  timer_halt,
    // Run state and events
    output logic             timer_zero_active,
    output logic             timer_one_active,
    output logic             timer_two_active,
    output logic             timer_three_active,
    output logic             timer_zero_underflow,
    output logic             irq
);

    function automatic logic is_mapped(input logic [5:0] idx);
        is_mapped = (idx >= IDX_RUN_CTRL && idx <= IDX_COUNT_LO) ||
                    idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a level counts once stages 2 and 3
    // agree, which rejects single-cycle glitches on slow radio lines
    logic [2:0] sync1_r, sync2_r, sync3_r, level_r, level_nxt, rise;

    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            level_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i]
                                                      : level_r[i];
        end
        rise = level_nxt & ~level_r;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            sync3_r <= 3'h0;
            level_r <= 3'h0;
        end
        else
        begin
            sync1_r <= {lfo_clock, rx_nibble, tx_end};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            level_r <= level_nxt;
        end
    end

    logic tx_rise, rx_rise, lfo_rise;
    assign tx_rise  = rise[0];
    assign rx_rise  = rise[1];
    assign lfo_rise = rise[2];

    ////////////////////////////////////////////////////////////////////////
    // Count clock enables: a phase accumulator gives 13.56 MHz on average;
    // single ticks jitter by one bus cycle, the long-run rate is exact
    logic [ACC_W-1:0]  acc_r, acc_nxt, acc_sum;
    logic [SLOW_W-1:0] slow_r, slow_nxt;
    logic              tick_sys_r, tick_sys_nxt, tick_slow_r, tick_slow_nxt;

    always_comb
    begin
        acc_sum       = acc_r + ACC_W'(CNT_CLK_KHZ);
        tick_sys_nxt  = acc_sum >= ACC_W'(SYS_CLK_KHZ);
        acc_nxt       = tick_sys_nxt ? acc_sum - ACC_W'(SYS_CLK_KHZ)
                                     : acc_sum;
        slow_nxt      = tick_sys_r ? slow_r + 1'b1 : slow_r;
        tick_slow_nxt = tick_sys_r && (slow_r == SLOW_W'(SLOW_DIV - 1));
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            acc_r       <= '0;
            slow_r      <= '0;
            tick_sys_r  <= 1'b0;
            tick_slow_r <= 1'b0;
        end
        else
        begin
            acc_r       <= acc_nxt;
            slow_r      <= slow_nxt;
            tick_sys_r  <= tick_sys_nxt;
            tick_slow_r <= tick_slow_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: address and data latch independently, the write
    // is done once both are held; only byte lane 0 carries register data
    logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
    logic [5:0]  wr_idx_r, wr_idx_nxt;
    logic [7:0]  wr_data_r, wr_data_nxt;
    logic        wr_lane_r, wr_lane_nxt;
    logic        bvalid_nxt, awready_nxt, wready_nxt, arready_nxt;
    logic        rvalid_nxt;
    logic [1:0]  bresp_nxt, rresp_nxt;
    logic [31:0] rdata_nxt;
    logic [7:0]  read_byte;
    logic [5:0]  rd_idx;
    logic        do_wr;

    assign do_wr  = aw_hold_r && w_hold_r && !bvalid;
    assign rd_idx = araddr[IDX_MSB:IDX_LSB];

    always_comb
    begin
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt  = w_hold_r;
        wr_idx_nxt  = wr_idx_r;
        wr_data_nxt = wr_data_r;
        wr_lane_nxt = wr_lane_r;
        bvalid_nxt  = bvalid;
        bresp_nxt   = bresp;
        if (awvalid && awready)
        begin
            aw_hold_nxt = 1'b1;
            wr_idx_nxt  = awaddr[IDX_MSB:IDX_LSB];
        end
        if (wvalid && wready)
        begin
            w_hold_nxt  = 1'b1;
            wr_data_nxt = wdata[7:0];
            wr_lane_nxt = wstrb[0];
        end
        if (do_wr)
        begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = is_mapped(wr_idx_r) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bvalid && bready)
        begin
            bvalid_nxt = 1'b0;
        end
        awready_nxt = !aw_hold_nxt && !bvalid_nxt;
        wready_nxt  = !w_hold_nxt && !bvalid_nxt;
    end

    // Read side: one outstanding read, data captured at address handshake
    always_comb
    begin
        rvalid_nxt  = rvalid;
        rdata_nxt   = rdata;
        rresp_nxt   = rresp;
        arready_nxt = arready;
        if (arvalid && arready)
        begin
            rvalid_nxt  = 1'b1;
            arready_nxt = 1'b0;
            rdata_nxt   = {24'h000000, read_byte};
            rresp_nxt   = is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid_nxt  = 1'b0;
            arready_nxt = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            wr_idx_r  <= 6'h00;
            wr_data_r <= 8'h00;
            wr_lane_r <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
            awready   <= 1'b0;
            wready    <= 1'b0;
            arready   <= 1'b0;
            rvalid    <= 1'b0;
            rdata     <= 32'h00000000;
            rresp     <= RESP_OKAY;
        end
        else
        begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r  <= w_hold_nxt;
            wr_idx_r  <= wr_idx_nxt;
            wr_data_r <= wr_data_nxt;
            wr_lane_r <= wr_lane_nxt;
            bvalid    <= bvalid_nxt;
            bresp     <= bresp_nxt;
            awready   <= awready_nxt;
            wready    <= wready_nxt;
            arready   <= arready_nxt | (!rvalid_nxt && !arready);
            rvalid    <= rvalid_nxt;
            rdata     <= rdata_nxt;
            rresp     <= rresp_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software-visible configuration registers
    logic [7:0]  ctrl_r, ctrl_nxt, reload_hi_r, reload_hi_nxt;
    logic [7:0]  reload_lo_r, reload_lo_nxt, mask_r, mask_nxt;
    logic [7:0]  status_r, status_nxt;
    logic [3:1]  run_r, run_nxt;
    logic        wr_ok, wr_run;

    assign wr_ok  = do_wr && wr_lane_r;
    assign wr_run = wr_ok && wr_idx_r == IDX_RUN_CTRL;

    always_comb
    begin
        ctrl_nxt      = ctrl_r;
        reload_hi_nxt = reload_hi_r;
        reload_lo_nxt = reload_lo_r;
        mask_nxt      = mask_r;
        if (wr_ok)
        begin
            case (wr_idx_r)
                IDX_T0_CTRL:   ctrl_nxt = wr_data_r & CTRL_RW_MASK;
                IDX_RELOAD_HI: reload_hi_nxt = wr_data_r;
                IDX_RELOAD_LO: reload_lo_nxt = wr_data_r;
                IDX_IRQ_MASK:  mask_nxt = wr_data_r;
                default:       mask_nxt = mask_r;
            endcase
        end
        // Other timers stop themselves; an enabled write still overrides
        run_nxt = run_r & ~timer_halt;
        for (int i = 1; i < TIMERS; i++)
        begin
            if (wr_run && wr_data_r[EN_LSB + i])
            begin
                run_nxt[i] = wr_data_r[RUN_LSB + i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timer zero: start/stop arbitration, counting and underflow
    t0_state_type     state_r, state_nxt;
    start_mode_type   mode;
    clock_select_type clk_sel;
    logic [15:0]      count_r, count_nxt, reload;
    logic             running, lfo_mode, tick, sw_start, sw_stop;
    logic             hw_start, hw_stop, start_evt, stop_evt, uf_evt;
    logic             uf_r, irq_nxt;

    assign mode     = start_mode_type'(ctrl_r[START_MSB:START_LSB]);
    assign clk_sel  = clock_select_type'(ctrl_r[CLKSEL_MSB:CLKSEL_LSB]);
    assign reload   = {reload_hi_r, reload_lo_r};
    assign running  = state_r == T0_RUNNING;
    assign lfo_mode = ctrl_r[START_MSB];
    assign sw_start = wr_run && wr_data_r[EN_LSB] && wr_data_r[RUN_LSB];
    assign sw_stop  = wr_run && wr_data_r[EN_LSB] && !wr_data_r[RUN_LSB];

    // Hardware events; software writes win when both land together
    always_comb
    begin
        hw_start  = (mode == START_TX_END && tx_rise) ||
                    (lfo_mode && lfo_rise && !running);
        hw_stop   = (!lfo_mode && ctrl_r[STOP_RX_BIT] && rx_rise)
                    || (lfo_mode && lfo_rise && running);
        start_evt = sw_start || (!sw_stop && hw_start);
        stop_evt  = !start_evt && (sw_stop || hw_stop);
        case (clk_sel)
            CLK_SYS:   tick = tick_sys_r;
            CLK_SLOW:  tick = tick_slow_r;
            CLK_T2_UF: tick = timer_two_underflow;
            CLK_T1_UF: tick = timer_one_underflow;
            default:   tick = 1'b0;
        endcase
    end

    // Trim mode 10 parks at zero without underflow until the next edge
    always_comb
    begin
        state_nxt = state_r;
        count_nxt = count_r;
        uf_evt    = 1'b0;
        if (start_evt)
        begin
            state_nxt = T0_RUNNING;
            count_nxt = reload;
        end
        else if (stop_evt)
        begin
            state_nxt = T0_STOPPED;
        end
        else if (running && tick)
        begin
            if (count_r != COUNT_RESET)
            begin
                count_nxt = count_r - 1'b1;
            end
            else if (mode != START_LFO)
            begin
                uf_evt = 1'b1;
                if (ctrl_r[AUTO_BIT])
                begin
                    count_nxt = reload;
                end
                else
                begin
                    state_nxt = T0_STOPPED;
                end
            end
        end
        // Underflow set wins over a write-one-to-clear in the same cycle
        status_nxt = status_r;
        if (wr_ok && wr_idx_r == IDX_IRQ_STATUS)
        begin
            status_nxt = status_r & ~wr_data_r;
        end
        status_nxt[UF_IRQ_BIT] = status_nxt[UF_IRQ_BIT] | uf_evt;
        irq_nxt = |(status_nxt & mask_nxt);
    end

    // Register read mux; counter bytes are only trustworthy outside rx
    always_comb
    begin
        case (rd_idx)
            IDX_RUN_CTRL:   read_byte = {run_r, running, 4'h0};
            IDX_T0_CTRL:    read_byte = ctrl_r;
            IDX_RELOAD_HI:  read_byte = reload_hi_r;
            IDX_RELOAD_LO:  read_byte = reload_lo_r;
            IDX_COUNT_HI:   read_byte = count_r[15:8];
            IDX_COUNT_LO:   read_byte = count_r[7:0];
            IDX_IRQ_STATUS: read_byte = status_r;
            IDX_IRQ_MASK:   read_byte = mask_r;
            default:        read_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r      <= CTRL_RESET;
            reload_hi_r <= RELOAD_RESET;
            reload_lo_r <= RELOAD_RESET;
            mask_r      <= 8'h00;
            status_r    <= 8'h00;
            run_r       <= 3'h0;
            state_r     <= T0_STOPPED;
            count_r     <= COUNT_RESET;
            uf_r        <= 1'b0;
            irq         <= 1'b0;
        end
        else
        begin
            ctrl_r      <= ctrl_nxt;
            reload_hi_r <= reload_hi_nxt;
            reload_lo_r <= reload_lo_nxt;
            mask_r      <= mask_nxt;
            status_r    <= status_nxt;
            run_r       <= run_nxt;
            state_r     <= state_nxt;
            count_r     <= count_nxt;
            uf_r        <= uf_evt;
            irq         <= irq_nxt;
        end
    end

    assign timer_zero_active    = state_r[1];
    assign timer_one_active     = run_r[1];
    assign timer_two_active     = run_r[2];
    assign timer_three_active   = run_r[3];
    assign timer_zero_underflow = uf_r;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_sw_start;
        sw_start;
    endsequence

    sequence s_zero_tick;
        running && tick && count_r == COUNT_RESET && mode != START_LFO &&
        !start_evt && !stop_evt;
    endsequence

    property p_run_masked;
        wr_run && wr_data_r[3:1] == 3'h0 && timer_halt == 3'h0
        |=> run_r == $past(run_r);
    endproperty
    a_run_masked: assert property (p_run_masked)
        else $error("run bit changed without its enable");

    property p_sw_start;
        s_sw_start |=> timer_zero_active && count_r == $past(reload);
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("enabled start did not load and run");

    property p_enable_wo;
        arvalid && arready && rd_idx == IDX_RUN_CTRL
        |=> rvalid && rdata[3:0] == 4'h0;
    endproperty
    a_enable_wo: assert property (p_enable_wo)
        else $error("enable bits read back non-zero");

    property p_stop_rx;
        running && !lfo_mode && ctrl_r[STOP_RX_BIT] && rx_rise && !start_evt
        |=> !timer_zero_active;
    endproperty
    a_stop_rx: assert property (p_stop_rx)
        else $error("stop on receive missed");

    property p_trim_ignores_rx;
        running && lfo_mode && rx_rise && !lfo_rise && !wr_run && !tick
        |=> timer_zero_active;
    endproperty
    a_trim_ignores_rx: assert property (p_trim_ignores_rx)
        else $error("trim mode stopped on receive");

    property p_auto_reload;
        s_zero_tick ##0 ctrl_r[AUTO_BIT]
        |=> timer_zero_active && count_r == $past(reload);
    endproperty
    a_auto_reload: assert property (p_auto_reload)
        else $error("auto restart did not reload");

    property p_one_shot;
        // A fresh start one cycle later is legal and may rerun the timer
        s_zero_tick ##0 !ctrl_r[AUTO_BIT]
        |=> !timer_zero_active ##1 (!timer_zero_active || $past(start_evt));
    endproperty
    a_one_shot: assert property (p_one_shot)
        else $error("one-shot timer kept running");

    property p_uf_flag;
        s_zero_tick |=> timer_zero_underflow ##0 status_r[UF_IRQ_BIT];
    endproperty
    a_uf_flag: assert property (p_uf_flag)
        else $error("underflow did not set flag");

    property p_reload_quiet;
        wr_ok && (wr_idx_r == IDX_RELOAD_HI || wr_idx_r == IDX_RELOAD_LO)
        && running && !tick && !start_evt && !stop_evt
        |=> count_r == $past(count_r);
    endproperty
    a_reload_quiet: assert property (p_reload_quiet)
        else $error("reload write disturbed count");

endmodule

// [verification/timer_run_control_bench.sv]
`timescale 1ns/100ps
module timer_run_control_bench
    import timer_pkg::*;
;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs, cas;
    logic [2:0]  evt;
    logic        act0, act1, act2, act3, uf0, irq;
    logic [7:0]  rv;
    int          err_total, total_checks, c;
    // Register rows: index, written byte, read-back byte, response
    logic [5:0] r_idx [6] = '{IDX_T0_CTRL, IDX_RELOAD_HI, IDX_RELOAD_LO,
                              IDX_RUN_CTRL, IDX_IRQ_MASK, 6'h3f};
    logic [7:0] r_wd [6] = '{8'hff, 8'h12, 8'h34, 8'hf0, 8'h01, 8'h5a};
    logic [7:0] r_rd [6] = '{8'hbb, 8'h12, 8'h34, 8'h00, 8'h01, 8'h00};
    logic [1:0] r_rs [6] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY,
                             RESP_OKAY, RESP_SLVERR};
    ////////////////////////////////////////////////////////////////////////
    timer_run_control dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .tx_end(evt[0]), .rx_nibble(evt[1]),
        .lfo_clock(evt[2]), .timer_one_underflow(cas[0]),
        .timer_two_underflow(cas[1]), .timer_halt(3'b000),
        .timer_zero_active(act0), .timer_one_active(act1),
        .timer_two_active(act2), .timer_three_active(act3),
        .timer_zero_underflow(uf0), .irq(irq));
    ////////////////////////////////////////////////////////////////////////
    // Free-running bus clock
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        @(posedge aclk);
        awaddr <= {a, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && dd))
        begin
            @(posedge aclk);
            if (!ad && awready) awvalid <= 1'b0;
            if (awready) ad = 1'b1;
            if (!dd && wready) wvalid <= 1'b0;
            if (wready) dd = 1'b1;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a);
        @(posedge aclk);
        araddr <= {a, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rv = rdata[7:0];
        rs = rresp;
        rready <= 1'b0;
    endtask
    // Pins are asynchronous, so pulses are held long enough to be seen
    task automatic pin(input logic [2:0] m);
        @(posedge aclk);
        evt <= m;
        repeat (3) @(posedge aclk);
        evt <= 3'b000;
        repeat (10) @(posedge aclk);
    endtask
    // One-cycle underflow pulse from a neighbour timer, then count ours
    task automatic pulse(input logic [1:0] m);
        @(posedge aclk);
        cas <= m;
        @(posedge aclk);
        cas <= 2'b00;
        count_uf(10);
    endtask
    // Counts underflow pulses over a fixed span
    task automatic count_uf(input int n);
        c = 0;
        repeat (n)
        begin
            @(posedge aclk);
            if (uf0 === 1'b1) c++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole sequence needs a few thousand cycles
    initial
    begin
        repeat (20000) @(posedge aclk);
        err_total++;
        test_done();
    end
    // Main sequence
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, cas} = '0;
        {awaddr, araddr, wdata, evt} = '0;
        wstrb = 4'hf;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(IDX_RUN_CTRL);
        chk("run reset", 8'h00, rv);
        for (int i = 0; i < 6; i++)
        begin
            wr(r_idx[i], r_wd[i]);
            chk("wr resp", r_rs[i], rs);
            rd(r_idx[i]);
            chk("rd data", r_rd[i], rv);
            chk("rd resp", r_rs[i], rs);
        end
        $display("test registers done");
        wr(IDX_T0_CTRL, 8'h00);
        wr(IDX_RELOAD_HI, 8'h00);
        wr(IDX_RELOAD_LO, 8'h03);
        wr(IDX_RUN_CTRL, 8'h11);
        // A reload of ff here would push the underflow far past the span
        wr(IDX_RELOAD_LO, 8'hff);
        count_uf(200);
        chk("one shot uf", 1, c);
        chk("active", 1'b0, act0);
        rd(IDX_RUN_CTRL);
        chk("run after zero", 8'h00, rv);
        rd(IDX_IRQ_STATUS);
        chk("status", 8'h01, rv);
        chk("irq", 1'b1, irq);
        wr(IDX_IRQ_STATUS, 8'h01);
        chk("irq cleared", 1'b0, irq);
        $display("test one shot done");
        wr(IDX_RUN_CTRL, 8'hee);
        rd(IDX_RUN_CTRL);
        chk("run set", 8'he0, rv);
        wr(IDX_RUN_CTRL, 8'h02);
        rd(IDX_RUN_CTRL);
        chk("run masked", 8'hc0, rv);
        chk("timer one", 1'b0, act1);
        chk("timer three", 1'b1, act3);
        chk("timer two", 1'b1, act2);
        $display("test run bits done");
        wr(IDX_RELOAD_LO, 8'h03);
        wr(IDX_T0_CTRL, 8'h08);
        wr(IDX_RUN_CTRL, 8'h11);
        count_uf(300);
        chk("restarts", 1'b1, c >= 3);
        chk("still active", 1'b1, act0);
        wr(IDX_RUN_CTRL, 8'h01);
        chk("sw stop", 1'b0, act0);
        $display("test restart done");
        wr(IDX_T0_CTRL, 8'h09);
        wr(IDX_RELOAD_LO, 8'h00);
        wr(IDX_RUN_CTRL, 8'h11);
        // One slow tick per 64 fast ones: one or two underflows fit here
        count_uf(2300);
        chk("slow rate", 1'b1, c >= 1 && c <= 2);
        wr(IDX_RUN_CTRL, 8'h01);
        $display("test slow clock done");
        wr(IDX_T0_CTRL, 8'h02);
        wr(IDX_RELOAD_LO, 8'h01);
        wr(IDX_RUN_CTRL, 8'h11);
        count_uf(40);
        chk("no cascade tick", 0, c);
        pulse(2'b01);
        rd(IDX_COUNT_LO);
        chk("t1 ignored", 8'h01, rv);
        pulse(2'b10);
        rd(IDX_COUNT_LO);
        chk("t2 tick", 8'h00, rv);
        pulse(2'b10);
        chk("t2 cascade", 1, c);
        wr(IDX_T0_CTRL, 8'h03);
        wr(IDX_RELOAD_LO, 8'h00);
        wr(IDX_RUN_CTRL, 8'h11);
        pulse(2'b01);
        chk("cascade tick", 1, c);
        $display("test cascade done");
        wr(IDX_RELOAD_HI, 8'hff);
        wr(IDX_T0_CTRL, 8'h80);
        wr(IDX_RUN_CTRL, 8'h11);
        pin(3'b010);
        chk("rx stop", 1'b0, act0);
        wr(IDX_T0_CTRL, 8'ha0);
        wr(IDX_RUN_CTRL, 8'h11);
        pin(3'b010);
        chk("trim ignores rx", 1'b1, act0);
        pin(3'b100);
        chk("lfo stop", 1'b0, act0);
        pin(3'b100);
        chk("lfo start", 1'b1, act0);
        wr(IDX_RUN_CTRL, 8'h01);
        wr(IDX_T0_CTRL, 8'h00);
        pin(3'b001);
        chk("no auto start", 1'b0, act0);
        wr(IDX_T0_CTRL, 8'h10);
        pin(3'b001);
        chk("tx start", 1'b1, act0);
        $display("test pins done");
        // Reset in mid-run, with timers running
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(IDX_RUN_CTRL);
        chk("run after reset", 8'h00, rv);
        chk("active after reset", 1'b0, act0);
        $display("test reset done");
        test_done();
    end
endmodule
